/* fic_fault_cmd_regs.sv */
// Fault flag register, interrupt-request command and software reset command
// of a switch-detection device, reached over a 32-bit SPI frame.
// Assumes event inputs are one-cycle pulses on i_clk_sys, and the supply and
// temperature comparator levels are asynchronous and synchronised here.
`timescale 1ns/100ps
module fic_fault_cmd_regs import fic_pkg::*; #(
    parameter int PULSE_CYC = INT_PULSE_CYC
) (
    input wire logic i_clk_sys,                  // System clock, 20 MHz
    input wire logic i_nrst,                     // Sync reset, active low
    input wire logic i_sclk,                     // SPI clock from host
    input wire logic i_cs_b,                     // SPI chip select, low
    input wire logic i_mosi,                     // SPI data in
    input wire logic [21:0] i_switch_status,     // Live switch states
    input wire logic i_switch_change,            // Switch changed, pulse
    input wire logic i_ext_status_event,         // Status event, pulse
    input wire logic i_hash_mismatch,            // Checksum mismatch level
    input wire logic i_batt_undervoltage,        // Async comparator level
    input wire logic i_batt_overvoltage,         // Async comparator level
    input wire logic i_temp_warning,             // Async comparator level
    input wire logic i_temp_limit,               // Async comparator level
    input wire logic i_int_pin_wake,             // Wake by int pin, pulse
    input wire logic i_wake_pin_wake,            // Wake by wake pin, pulse
    input wire logic i_spi_wake,                 // Wake by SPI, pulse
    input wire logic i_por_event,                // Supply collapse, pulse
    output logic o_miso,                         // SPI data out
    output logic o_miso_oe,                      // SPI data out enable
    output logic o_int_n,                        // Interrupt pin level
    output logic o_int_oe,                       // Interrupt pin enable
    output logic o_regs_reset                    // Reset other registers
);
    localparam int ASYNC_N = 4;
    localparam int PCW = $clog2(PULSE_CYC + 1);

    logic [31:0] rx_word;
    logic rx_full;
    logic rx_over;
    logic [2:0] cs_sync_q;
    logic [ASYNC_N-1:0] lvl_s1_q;
    logic [ASYNC_N-1:0] lvl_s2_q;
    logic [FLAG_BITS-1:0] flags_q;
    logic [FLAG_BITS-1:0] flags_d;
    logic [FLAG_BITS-1:0] flag_set;
    logic intflg_q;
    logic intflg_d;
    logic [31:0] tx_q;
    logic [31:0] tx_d;
    logic [PCW-1:0] pulse_cnt_q;
    logic [PCW-1:0] pulse_cnt_d;
    logic regs_reset_q;

    fic_spi_link u_link (
        .i_nrst(i_nrst),
        .i_sclk(i_sclk),
        .i_cs_b(i_cs_b),
        .i_mosi(i_mosi),
        .i_tx_word(tx_q),
        .o_miso(o_miso),
        .o_miso_oe(o_miso_oe),
        .o_rx_word(rx_word),
        .o_full(rx_full),
        .o_over(rx_over)
    );

    // The captured frame is read only after chip select has been seen high
    // through two flip-flops, so the link word is long settled by then.
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            cs_sync_q <= 3'h7;
        end else begin
            cs_sync_q <= {cs_sync_q[1:0], i_cs_b};
        end
    end

    wire frame_end = cs_sync_q[1] & ~cs_sync_q[2];

    // Comparator levels arrive from the analog side.
    wire [ASYNC_N-1:0] lvl_raw = {i_batt_undervoltage, i_batt_overvoltage,
                                  i_temp_warning, i_temp_limit};
    genvar gs;
    generate
        for (gs = 0; gs < ASYNC_N; gs++) begin : g_sync
            always_ff @(posedge i_clk_sys) begin
                if (!i_nrst) begin
                    lvl_s1_q[gs] <= 1'b0;
                    lvl_s2_q[gs] <= 1'b0;
                end else begin
                    lvl_s1_q[gs] <= lvl_raw[gs];
                    lvl_s2_q[gs] <= lvl_s1_q[gs];
                end
            end
        end
    endgenerate

    wire uv_lvl = lvl_s2_q[3];
    wire ov_lvl = lvl_s2_q[2];
    wire tw_lvl = lvl_s2_q[1];
    wire tl_lvl = lvl_s2_q[0];

    // Frame decode.
    wire [6:0] cmd_addr = rx_word[31:25];
    wire cmd_write = rx_word[24];
    wire [23:0] cmd_data = rx_word[23:0];
    wire data_zero = (cmd_data == 24'h00_0000);
    wire count_ok = rx_full & ~rx_over;
    wire addr_ok = (cmd_addr <= ADDR_LAST);
    wire is_fault_rd = (cmd_addr == ADDR_FAULT) & ~cmd_write;
    wire is_sw_rd = (cmd_addr == ADDR_SWITCH_STATUS) & ~cmd_write;
    wire is_int_wr = (cmd_addr == ADDR_INT_REQ) & cmd_write;
    wire is_rst_wr = (cmd_addr == ADDR_RESET) & cmd_write;
    // A command on one of these words must carry zero data to count.
    wire bad_data = (is_int_wr | is_rst_wr) & ~data_zero;
    wire frame_ok = count_ok & addr_ok & ~bad_data;
    wire spi_err = frame_end & ~frame_ok;
    wire fault_rd = frame_end & frame_ok & is_fault_rd;
    wire sw_rd = frame_end & frame_ok & is_sw_rd;
    wire int_req = frame_end & frame_ok & is_int_wr;
    wire soft_rst = frame_end & frame_ok & is_rst_wr;

    // Set sources per flag bit; condition levels keep a flag set while the
    // condition lasts, so a read during the condition cannot clear it.
    always_comb begin
        flag_set = '0;
        flag_set[BIT_SPI_ERR] = spi_err;
        flag_set[BIT_HASH] = i_hash_mismatch;
        flag_set[BIT_UV] = uv_lvl;
        flag_set[BIT_OV] = ov_lvl;
        flag_set[BIT_TEMP_WARN] = tw_lvl;
        flag_set[BIT_TEMP_LIMIT] = tl_lvl | (flags_q[BIT_TEMP_LIMIT] &
                                             tw_lvl);
        flag_set[BIT_INT_WAKE] = i_int_pin_wake;
        flag_set[BIT_PIN_WAKE] = i_wake_pin_wake;
        flag_set[BIT_SPI_WAKE] = i_spi_wake;
        flag_set[BIT_POR] = i_por_event;
    end

    // One rule for every flag except unused bit 8, tied to zero: a set in the clearing cycle wins.
    genvar gf;
    generate
        for (gf = 0; gf < FLAG_BITS; gf++) begin : g_flag
            if (gf == BIT_UNUSED8) begin : g_unused
                assign flags_d[gf] = 1'b0;
            end else begin : g_used
                assign flags_d[gf] = flag_set[gf] |
                                     (flags_q[gf] & ~fault_rd);
            end
        end
    endgenerate

    wire fault_sum = |flags_q;
    wire new_fault = |(flag_set & ~flags_q);

    // The interrupt request is deliberately absent from the set terms.
    assign intflg_d = i_switch_change | i_ext_status_event | new_fault |
                      (intflg_q & ~(sw_rd | fault_rd));

    // Replies; the first byte echoes the command address and R/W bit, except after a reset command, which gets the switch status word.
    wire [7:0] echo = {cmd_addr, cmd_write};
    wire [31:0] fault_word = {echo, 1'b0, intflg_q,
                              11'h000, flags_q};
    wire [31:0] switch_word = {ADDR_SWITCH_STATUS, 1'b0, fault_sum,
                               intflg_q, i_switch_status};
    wire [31:0] echo_word = {echo, fault_sum, intflg_q, 22'h00_0000};

    always_comb begin
        tx_d = tx_q;
        if (frame_end) begin
            if (fault_rd) begin
                tx_d = fault_word;
            end else if (sw_rd | soft_rst) begin
                tx_d = switch_word;
            end else begin
                tx_d = echo_word;
            end
        end
    end

    // Interrupt pulse timer; a new request restarts the full width.
    always_comb begin
        pulse_cnt_d = pulse_cnt_q;
        if (int_req) begin
            pulse_cnt_d = PCW'(PULSE_CYC);
        end else if (pulse_cnt_q != '0) begin
            pulse_cnt_d = pulse_cnt_q - PCW'(1);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            flags_q <= FLAGS_RST;
            intflg_q <= INTFLG_RST;
            tx_q <= TX_WORD_RST;
            pulse_cnt_q <= '0;
            regs_reset_q <= 1'b0;
        end else begin
            flags_q <= flags_d;
            intflg_q <= intflg_d;
            tx_q <= tx_d;
            pulse_cnt_q <= pulse_cnt_d;
            regs_reset_q <= soft_rst;
        end
    end

    // Open-drain style pin: it is only ever driven low.
    wire pulse_on = (pulse_cnt_q != '0);
    assign o_int_n = ~pulse_on;
    assign o_int_oe = pulse_on;
    assign o_regs_reset = regs_reset_q;
endmodule

/* fic_host_model.sv */
// Host model: SPI master, mode 0, MSB first, 30 ns serial clock.
// Assumes the bench calls xfer and keeps select high between frames.
`timescale 1ns/100ps
module fic_host_model (
    input wire logic i_miso, // Device data out
    output logic o_sclk, // Serial clock
    output logic o_cs_b, // Chip select
    output logic o_mosi // Data to device
);
    initial begin
        o_sclk = 1'b0;
        o_cs_b = 1'b1;
        o_mosi = 1'b0;
    end
    // The clock runs only inside a frame; nb may differ from 32 on purpose.
    task automatic xfer(input logic [31:0] w, input int nb,
            output logic [31:0] rx);
        rx = '0;
        o_cs_b = 1'b0;
        for (int i = 0; i < nb; i++) begin
            o_mosi = w[31 - (i % 32)];
            #15 o_sclk = 1'b1;
            rx = {rx[30:0], i_miso};
            #15 o_sclk = 1'b0;
        end
        #15 o_cs_b = 1'b1;
        // A released line must not keep showing its last bit.
        o_mosi = ~o_mosi;
    endtask
endmodule

/* fic_pkg.sv */
// Shared constants for the fault, interrupt-request and reset command block.
// Assumes a 32-bit SPI frame: 7-bit address, R/W bit, 24 data bits.
package fic_pkg;
    localparam int FRAME_BITS = 32;
    localparam int DATA_BITS = 24;
    localparam int SWITCH_BITS = 22;
    localparam int FLAG_BITS = 11;

    // Register addresses (bits 31..25 of a command word).
    localparam logic [6:0] ADDR_SWITCH_STATUS = 7'h1f;
    localparam logic [6:0] ADDR_FAULT = 7'h21;
    localparam logic [6:0] ADDR_INT_REQ = 7'h23;
    localparam logic [6:0] ADDR_RESET = 7'h24;
    localparam logic [6:0] ADDR_LAST = 7'h24;

    // Bit positions in the 24-bit data field.
    localparam int BIT_FAULT_SUM = 23;
    localparam int BIT_INTFLG = 22;
    localparam int BIT_SPI_ERR = 10;
    localparam int BIT_HASH = 9;
    localparam int BIT_UNUSED8 = 8;
    localparam int BIT_UV = 7;
    localparam int BIT_OV = 6;
    localparam int BIT_TEMP_WARN = 5;
    localparam int BIT_TEMP_LIMIT = 4;
    localparam int BIT_INT_WAKE = 3;
    localparam int BIT_PIN_WAKE = 2;
    localparam int BIT_SPI_WAKE = 1;
    localparam int BIT_POR = 0;

    // Reset values.
    localparam logic [FLAG_BITS-1:0] FLAGS_RST = 11'h001;
    localparam logic INTFLG_RST = 1'b1;
    localparam logic [31:0] TX_WORD_RST = 32'h0000_0000;

    // Interrupt pulse timing.
    localparam int INT_PULSE_US = 100;
    localparam int CLK_FREQ_MHZ = 20;
    localparam int INT_PULSE_CYC = INT_PULSE_US * CLK_FREQ_MHZ;
endpackage

/* fic_props_chk_props.sv */
// Port checks for the fault, interrupt-request and reset command block.
// Assumes it is bound into fic_fault_cmd_regs.
`timescale 1ns/100ps
module fic_props_chk #(
    parameter int PULSE_CYC = 2000
) (
    input wire logic i_clk_sys, // System clock
    input wire logic i_nrst, // Sync reset, active low
    input wire logic i_cs_b, // Chip select
    input wire logic o_miso_oe, // Data out enable
    input wire logic o_int_n, // Interrupt level
    input wire logic o_int_oe, // Interrupt enable
    input wire logic o_regs_reset // Register reset pulse
);
    logic [15:0] low_q;
    logic [15:0] low_d;
    // No reset needed: the pin idles high in reset, which zeroes the count.
    assign low_d = o_int_n ? 16'h0000 : low_q + 16'h0001;
    always_ff @(posedge i_clk_sys) begin
        low_q <= low_d;
    end
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_nrst);
    int_oe_match_a: assert property (o_int_oe == !o_int_n)
        else $error("interrupt enable differs from level");
    pulse_len_a: assert property ($rose(o_int_n) |->
        low_q == PULSE_CYC)
        else $error("interrupt pulse width wrong");
    pulse_min_a: assert property ($fell(o_int_n) |=> !o_int_n [*8])
        else $error("interrupt pulse too short");
    pulse_cause_a: assert property ($fell(o_int_n) |->
        $past(i_cs_b) && $past(i_cs_b, 2))
        else $error("interrupt pulse inside a frame");
    miso_oe_a: assert property (o_miso_oe == !i_cs_b)
        else $error("data out enable not following select");
    rst_one_a: assert property (o_regs_reset |=> !o_regs_reset)
        else $error("register reset longer than one cycle");
    rst_cause_a: assert property (o_regs_reset |->
        $past(i_cs_b) && $past(i_cs_b, 2))
        else $error("register reset inside a frame");
    cmd_excl_a: assert property (o_regs_reset |-> !$fell(o_int_n))
        else $error("reset and interrupt from one frame");
endmodule

bind fic_fault_cmd_regs fic_props_chk #(.PULSE_CYC(PULSE_CYC)) u_props (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_cs_b(i_cs_b),
    .o_miso_oe(o_miso_oe),
    .o_int_n(o_int_n),
    .o_int_oe(o_int_oe),
    .o_regs_reset(o_regs_reset)
);

/* fic_spi_link.sv */
// SPI shift engine running on the host's serial clock (mode 0).
// Assumes the serial clock runs only while chip select is low and that the
// transmit word is held stable by the caller while chip select is low.
`timescale 1ns/100ps
module fic_spi_link import fic_pkg::*; (
    input wire logic i_nrst,              // System reset, active low
    input wire logic i_sclk,              // Serial clock from the host
    input wire logic i_cs_b,              // Chip select, active low
    input wire logic i_mosi,              // Serial data in
    input wire logic [31:0] i_tx_word,    // Word to shift out
    output logic o_miso,                  // Serial data out
    output logic o_miso_oe,               // Drive enable for data out
    output logic [31:0] o_rx_word,        // Last word shifted in
    output logic o_full,                  // At least 32 clocks seen
    output logic o_over                   // More than 32 clocks seen
);
    logic [5:0] in_cnt_q;
    logic [5:0] out_cnt_q;
    logic [31:0] rx_q;
    logic full_q;
    logic over_q;
    wire link_clr = i_cs_b | ~i_nrst;
    wire in_sat = (in_cnt_q == 6'(FRAME_BITS + 1));
    wire in_first = (in_cnt_q == 6'h00);
    wire in_live = (in_cnt_q < 6'(FRAME_BITS));
    wire [4:0] out_idx = 5'h1f - out_cnt_q[4:0];
    wire out_live = (out_cnt_q < 6'(FRAME_BITS));

    // Counters restart with each frame; they are cleared while deselected.
    always_ff @(posedge i_sclk or posedge link_clr) begin
        if (link_clr) begin
            in_cnt_q <= 6'h00;
        end else if (!in_sat) begin
            in_cnt_q <= in_cnt_q + 6'h01;
        end
    end

    // The captured word and the count verdict survive chip select rising, so
    // the system side can read them once it has seen the frame end.
    always_ff @(posedge i_sclk or negedge i_nrst) begin
        if (!i_nrst) begin
            rx_q <= 32'h0000_0000;
            full_q <= 1'b0;
            over_q <= 1'b0;
        end else begin
            if (in_live) begin
                rx_q <= {rx_q[30:0], i_mosi};
            end
            full_q <= (in_cnt_q == 6'(FRAME_BITS - 1)) | (full_q & ~in_first);
            over_q <= (in_cnt_q >= 6'(FRAME_BITS)) | (over_q & ~in_first);
        end
    end

    // Data out changes on the falling edge so the host samples on rising.
    always_ff @(negedge i_sclk or posedge link_clr) begin
        if (link_clr) begin
            out_cnt_q <= 6'h00;
        end else if (out_live) begin
            out_cnt_q <= out_cnt_q + 6'h01;
        end
    end

    assign o_miso = out_live ? i_tx_word[out_idx] : 1'b0;
    assign o_miso_oe = ~i_cs_b;
    assign o_rx_word = rx_q;
    assign o_full = full_q;
    assign o_over = over_q;
endmodule

/* test_fault_interrupt_command_regs.sv */
// Self-checking bench for the fault, interrupt-request and reset block.
// Assumes the host model and the bound port checker.
`timescale 1ns/100ps
`define CHECK(a, e) begin n_compared++; if ((a) !== (e)) begin \
    failures++; $display("BAD %0t got %h want %h", $time, a, e); end end
module test_fault_interrupt_command_regs;
    import fic_pkg::*;
    localparam int PW = 20;
    localparam logic [31:0] FR = 32'h4200_0000;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [11:0] ev = '0;
    logic [21:0] sw = '0;
    logic sclk, cs_b, mosi, miso, miso_oe, int_n, int_oe, regs_rst;
    int failures = 0;
    int n_compared = 0;
    int n_pulse = 0;
    int n_rst = 0;
    int low_cnt = 0;
    int last_len = 0;
    logic [31:0] got, want_w;
    int bits[10] = '{0, 1, 2, 3, 4, 5, 6, 7, 9, 10};
    always #25 clk = ~clk;
    fic_host_model host (.i_miso(miso), .o_sclk(sclk), .o_cs_b(cs_b),
        .o_mosi(mosi));
    fic_fault_cmd_regs #(.PULSE_CYC(PW)) uut (.i_clk_sys(clk),
        .i_nrst(nrst), .i_sclk(sclk), .i_cs_b(cs_b), .i_mosi(mosi),
        .i_switch_status(sw), .i_switch_change(ev[8]),
        .i_ext_status_event(ev[11]), .i_hash_mismatch(ev[9]),
        .i_batt_undervoltage(ev[7]), .i_batt_overvoltage(ev[6]),
        .i_temp_warning(ev[5]), .i_temp_limit(ev[4]),
        .i_int_pin_wake(ev[3]), .i_wake_pin_wake(ev[2]),
        .i_spi_wake(ev[1]), .i_por_event(ev[0]), .o_miso(miso),
        .o_miso_oe(miso_oe), .o_int_n(int_n), .o_int_oe(int_oe),
        .o_regs_reset(regs_rst));
    always @(posedge clk) begin
        if (int_n === 1'b0) begin
            low_cnt++;
        end else if (low_cnt != 0) begin
            last_len = low_cnt;
            n_pulse++;
            low_cnt = 0;
        end
        if (regs_rst === 1'b1) n_rst++;
    end
    function automatic logic [31:0] fault_word(input int b);
        fault_word = 32'h4240_0000 | (32'h1 << b);
    endfunction
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic xf(input logic [31:0] w, input int nb, input bit chk,
            input logic [31:0] e);
        logic [31:0] rx;
        host.xfer(w, nb, rx);
        got = rx;
        if (chk) `CHECK(rx, e)
        step(8);
    endtask
    task automatic stop_test();
        if (failures == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // The sequence needs about 1400 cycles; this 20000-cycle limit allows over ten times that.
    initial begin
        #(20000 * 50);
        failures++;
        stop_test();
    end
    initial begin
        void'($urandom(32'h8cf7));
        step(3);
        nrst = 1'b1;
        step(2);
        xf(FR, 32, 1, 32'h0);
        xf(FR, 32, 1, 32'h4240_0001);
        foreach (bits[k]) begin
            xf(FR, 32, 1, 32'h4200_0000);
            if (bits[k] == 10) begin
                xf({7'($urandom_range(37, 127)), 25'($urandom)},
                    $urandom_range(31, 33), 0, 0);
            end else begin
                ev[bits[k]] = 1'b1;
                step(bits[k] < 4 ? 1 : 6);
                ev = '0;
                step(6);
            end
            xf(FR, 32, 0, 0);
            xf(FR, 32, 0, 0);
            want_w = fault_word(bits[k]);
            `CHECK(got[31:11], want_w[31:11])
            `CHECK(got[10:6], want_w[10:6])
            `CHECK(got[5:0], want_w[5:0])
        end
        // Conditions still present at a read must keep their flags set.
        ev[4] = 1'b1;
        ev[5] = 1'b1;
        ev[9] = 1'b1;
        step(6);
        ev[4] = 1'b0;
        step(6);
        xf(FR, 32, 0, 0);
        xf(FR, 32, 1, 32'h4240_0230);
        ev = '0;
        step(6);
        xf(FR, 32, 1, 32'h4200_0230);
        xf(FR, 32, 1, 32'h4200_0230);
        sw = 22'($urandom);
        ev[8 + 3 * $urandom_range(0, 1)] = 1'b1;
        step(1);
        ev = '0;
        step(3);
        xf(32'h3e00_0000, 32, 1, 32'h4200_0000);
        xf(32'h4700_0000, 32, 1, {8'h3e, 2'b01, sw});
        `CHECK({int_n, int_oe, miso_oe}, 3'b010)
        step(PW + 10);
        `CHECK({int_n, int_oe, miso_oe}, 3'b100)
        `CHECK(n_pulse, 1)
        `CHECK(last_len, PW)
        xf(32'h4900_0000, 32, 1, 32'h4700_0000);
        `CHECK(n_rst, 1)
        xf(FR, 32, 1, {8'h3e, 2'b00, sw});
        xf(32'h4700_0000 | 32'($urandom_range(1, 255)), 32, 0, 0);
        xf(32'h4901_0000, 32, 0, 0);
        step(PW + 10);
        `CHECK(n_pulse, 1)
        `CHECK(n_rst, 1)
        xf(FR, 32, 0, 0);
        xf(FR, 32, 1, fault_word(10));
        stop_test();
    end
endmodule
